// ==== hw/async_serial_receiver.sv ====
// Asynchronous serial receive path with register port and interrupt
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "serial_rx_map.svh"

module async_serial_receiver #(
  parameter int DIV_WIDTH = 16,
  parameter int QUEUE_DEPTH = `QUEUE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic serial_in_pin,
  output logic irq
);

  // Software registers
  logic [7:0] rxCtl_r; // Writable bits of receive_status_control
  logic [7:0] rxCtl_nxt;
  logic [7:0] txCtl_r; // transmit_status_control
  logic [7:0] txCtl_nxt;
  logic [7:0] baudCtl_r; // baud_control, writable part
  logic [7:0] baudCtl_nxt;
  logic [15:0] divisor_r; // Baud divisor pair
  logic [15:0] divisor_nxt;
  logic [7:0] irqStat_r; // Sticky event bits
  logic [7:0] irqStat_nxt;
  logic [7:0] irqMask_r; // Interrupt mask
  logic [7:0] irqMask_nxt;
  logic [7:0] rdData_r; // Read data, one cycle after strobe
  logic [7:0] rdData_nxt;
  logic overflow_r; // Overflow fault, held until enable drops
  logic overflow_nxt;

  // Recovery state
  serial_rx_pkg::recover_state_type state_r;
  serial_rx_pkg::recover_state_type state_nxt;
  logic [3:0] phase_r; // Oversample count within a bit
  logic [3:0] phase_nxt;
  logic [3:0] bitCnt_r; // Data bits taken so far
  logic [3:0] bitCnt_nxt;
  logic [8:0] shift_r; // receive_shift_reg, not software visible
  logic [8:0] shift_nxt;
  logic [2:0] votes_r; // Three samples round the centre
  logic [2:0] votes_nxt;
  logic linePrev_r; // Previous line level for edge detect
  logic linePrev_nxt;

  // Wires
  logic portOn;
  logic rxRun;
  logic tick;
  logic push;
  logic pop;
  logic qNotEmpty;
  logic qFull;
  serial_rx_pkg::rx_char_type pushChar;
  serial_rx_pkg::rx_char_type headChar;
  serial_rx_pkg::reg_req_type req;

  assign req = '{wrStrobe: regWr, rdStrobe: regRd, addr: regAddr, wrData: regWrData};
  assign portOn = rxCtl_r[`BIT_SERIAL_PORT_ON];
  // Receiver active only with enable set, async mode, port on
  assign rxRun = rxCtl_r[`BIT_RECEIVE_ENABLE] && !txCtl_r[`BIT_CLOCKED_MODE] && portOn;

  // Majority of three votes
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Oversampling enable pulse
  baud_tick_gen #(
    .WIDTH(DIV_WIDTH)
  ) u_tick (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(rxRun),
    .divisor(DIV_WIDTH'(divisor_r)),
    .tick(tick)
  );

  // Character queue; clearing the port resets it
  rx_char_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .flush(!portOn),
    .push(push),
    .pushChar(pushChar),
    .pop(pop),
    .headChar(headChar),
    .notEmpty(qNotEmpty),
    .full(qFull)
  );

  // Data register read pops the oldest character
  assign pop = req.rdStrobe && (req.addr == `OFS_RECEIVE_BUFFER_PORT);

  // Line recovery: edge detect, start check, majority bits, stop
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    votes_nxt = votes_r;
    linePrev_nxt = serial_in_pin;
    push = 1'b0;
    pushChar = '{ninth: shift_r[8], data: shift_r[7:0], fault: 1'b0};
    if (!rxRun) begin
      state_nxt = serial_rx_pkg::IDLE;
      phase_nxt = '0;
    end else begin
      case (state_r)
        serial_rx_pkg::IDLE: begin
          // Falling edge starts a character
          if (linePrev_r && !serial_in_pin) begin
            state_nxt = serial_rx_pkg::START_CHECK;
            phase_nxt = '0;
          end
        end
        serial_rx_pkg::START_CHECK: begin
          if (tick) begin
            phase_nxt = phase_r + 1'b1;
            // Half a bit later the line must still be low
            if (phase_r == 4'(`HALF_BIT_TICKS - 1)) begin
              phase_nxt = '0;
              bitCnt_nxt = '0;
              // High here: abandon quietly, no fault
              state_nxt = serial_in_pin ? serial_rx_pkg::IDLE : serial_rx_pkg::DATA_BITS;
            end
          end
        end
        serial_rx_pkg::DATA_BITS, serial_rx_pkg::STOP_BIT: begin
          if (tick) begin
            phase_nxt = phase_r + 1'b1;
            // Take two samples just before the centre and one at it
            if (phase_r == 4'hd || phase_r == 4'he) begin
              votes_nxt = {votes_r[1:0], serial_in_pin};
            end
            if (phase_r == 4'(`OVERSAMPLE_RATE - 1)) begin
              phase_nxt = '0;
              votes_nxt = '0;
              if (state_r == serial_rx_pkg::DATA_BITS) begin
                // Shift right so the first bit lands in the low end
                if (rxCtl_r[`BIT_NINTH_BIT_ENABLE]) begin
                  shift_nxt = {majority({votes_r[1:0], serial_in_pin}), shift_r[8:1]};
                end else begin
                  shift_nxt = {1'b0, majority({votes_r[1:0], serial_in_pin}), shift_r[7:1]};
                end
                bitCnt_nxt = bitCnt_r + 1'b1;
                if (bitCnt_r == (rxCtl_r[`BIT_NINTH_BIT_ENABLE] ? 4'h8 : 4'h7)) begin
                  state_nxt = serial_rx_pkg::STOP_BIT;
                end
              end else begin
                // Stop low is a framing fault for this character only
                pushChar.fault = !majority({votes_r[1:0], serial_in_pin});
                // Queue at once unless overflow blocks reception
                push = !overflow_r && !qFull;
                state_nxt = serial_rx_pkg::IDLE;
              end
            end
          end
        end
        default: begin
          state_nxt = serial_rx_pkg::IDLE;
        end
      endcase
    end
  end

  // Register the recovery state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= serial_rx_pkg::IDLE;
      phase_r <= '0;
      bitCnt_r <= '0;
      shift_r <= '0;
      votes_r <= '0;
      linePrev_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      votes_r <= votes_nxt;
      linePrev_r <= linePrev_nxt;
    end
  end

  // Register file, sticky events and read data
  always_comb begin
    logic overEvent;
    overEvent = 1'b0;
    rxCtl_nxt = rxCtl_r;
    txCtl_nxt = txCtl_r;
    baudCtl_nxt = baudCtl_r;
    divisor_nxt = divisor_r;
    irqMask_nxt = irqMask_r;
    irqStat_nxt = irqStat_r;
    overflow_nxt = overflow_r;
    rdData_nxt = '0;
    // Third whole character into a full queue
    if (state_r == serial_rx_pkg::STOP_BIT && tick && phase_r == 4'(`OVERSAMPLE_RATE - 1) && qFull) begin
      overEvent = 1'b1;
    end
    if (req.wrStrobe) begin
      case (req.addr)
        `OFS_RECEIVE_STATUS_CONTROL: begin
          // Status bits are read-only
          rxCtl_nxt = req.wrData & 8'hd8;
        end
        // Shifter-empty bit always reads one; no transmitter lives here
        `OFS_TRANSMIT_STATUS_CONTROL: txCtl_nxt = (req.wrData & 8'hfd) | 8'h02;
        `OFS_BAUD_CONTROL: baudCtl_nxt = req.wrData & 8'h3f;
        `OFS_BAUD_DIVISOR_LOW: divisor_nxt[7:0] = req.wrData;
        `OFS_BAUD_DIVISOR_HIGH: divisor_nxt[15:8] = req.wrData;
        `OFS_IRQ_STATUS: irqStat_nxt = irqStat_r & ~req.wrData;
        `OFS_IRQ_MASK: irqMask_nxt = req.wrData;
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    // Overflow clears only by dropping an enable; a new event wins
    if (!rxCtl_nxt[`BIT_RECEIVE_ENABLE] || !rxCtl_nxt[`BIT_SERIAL_PORT_ON]) begin
      overflow_nxt = 1'b0;
    end
    if (overEvent) begin
      overflow_nxt = 1'b1;
      irqStat_nxt[`BIT_IRQ_OVERFLOW] = 1'b1;
    end
    if (push) begin
      irqStat_nxt[`BIT_IRQ_PENDING] = 1'b1;
      irqStat_nxt[`BIT_IRQ_FRAMING] = irqStat_nxt[`BIT_IRQ_FRAMING] | pushChar.fault;
    end
    if (req.rdStrobe) begin
      case (req.addr)
        `OFS_RECEIVE_STATUS_CONTROL: begin
          // Fault and ninth bit belong to the oldest unread character
          rdData_nxt = rxCtl_r;
          // Port off hides the queue a cycle before its flush lands
          rdData_nxt[`BIT_STOP_BIT_FAULT] = portOn && qNotEmpty && headChar.fault;
          rdData_nxt[`BIT_OVERFLOW_FAULT] = overflow_r;
          rdData_nxt[`BIT_RECEIVED_NINTH_BIT] = portOn && qNotEmpty && headChar.ninth;
        end
        `OFS_TRANSMIT_STATUS_CONTROL: rdData_nxt = txCtl_r;
        `OFS_BAUD_CONTROL: begin
          rdData_nxt = baudCtl_r;
          rdData_nxt[`BIT_RECEIVER_IDLE] = (state_r == serial_rx_pkg::IDLE);
        end
        `OFS_BAUD_DIVISOR_LOW: rdData_nxt = divisor_r[7:0];
        `OFS_BAUD_DIVISOR_HIGH: rdData_nxt = divisor_r[15:8];
        // Only route to received data; shifter has no address
        `OFS_RECEIVE_BUFFER_PORT: rdData_nxt = qNotEmpty ? headChar.data : 8'h00;
        `OFS_IRQ_STATUS: rdData_nxt = irqStat_r;
        `OFS_IRQ_MASK: rdData_nxt = irqMask_r;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // Register the software-visible state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxCtl_r <= `RST_RECEIVE_STATUS_CONTROL;
      txCtl_r <= `RST_TRANSMIT_STATUS_CONTROL;
      baudCtl_r <= `RST_BAUD_CONTROL;
      divisor_r <= `RST_BAUD_DIVISOR;
      irqStat_r <= 8'h00;
      irqMask_r <= `RST_IRQ_MASK;
      rdData_r <= 8'h00;
      overflow_r <= 1'b0;
    end else begin
      rxCtl_r <= rxCtl_nxt;
      txCtl_r <= txCtl_nxt;
      baudCtl_r <= baudCtl_nxt;
      divisor_r <= divisor_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      rdData_r <= rdData_nxt;
      overflow_r <= overflow_nxt;
    end
  end

  assign regRdData = rdData_r;
  // Level interrupt while any unmasked event stays set
  assign irq = |(irqStat_r & irqMask_r);

endmodule

`default_nettype wire

// ==== hw/baud_tick_gen.sv ====
// Baud divider producing the sixteen-times oversampling enable pulse
`timescale 1ns/100ps
`default_nettype none

module baud_tick_gen #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);

  logic [WIDTH-1:0] count_r; // Cycles left to the next tick
  logic [WIDTH-1:0] count_nxt;
  logic tick_r;
  logic tick_nxt;

  // Count down, reload with the divisor, pulse on reload
  always_comb begin
    count_nxt = count_r;
    tick_nxt = 1'b0;
    if (!run) begin
      // Restart phase whenever the receiver stops; frames within one run share the free-running phase
      count_nxt = divisor;
    end else if (count_r == '0) begin
      count_nxt = divisor;
      tick_nxt = 1'b1;
    end else begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Register the divider state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
      tick_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

`default_nettype wire

// ==== hw/rx_char_queue.sv ====
// Small first-in-first-out queue of received characters held in flip-flops
`timescale 1ns/100ps
`default_nettype none

module rx_char_queue #(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic flush,
  input wire logic push,
  input wire serial_rx_pkg::rx_char_type pushChar,
  input wire logic pop,
  output serial_rx_pkg::rx_char_type headChar,
  output logic notEmpty,
  output logic full
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  serial_rx_pkg::rx_char_type store_r [DEPTH]; // Character storage
  serial_rx_pkg::rx_char_type store_nxt [DEPTH];
  logic [IW-1:0] rdIdx_r; // Oldest entry
  logic [IW-1:0] rdIdx_nxt;
  logic [IW:0] fill_r; // Entries held
  logic [IW:0] fill_nxt;

  // Wrap an index around the queue depth
  function automatic logic [IW-1:0] wrapInc(input logic [IW-1:0] idx);
    wrapInc = (idx == IW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction

  // Next queue contents
  always_comb begin
    logic [IW-1:0] wrIdx;
    logic doPush;
    logic doPop;
    wrIdx = '0;
    doPop = pop && (fill_r != '0);
    doPush = push && ((fill_r != (IW+1)'(DEPTH)) || doPop);
    store_nxt = store_r;
    rdIdx_nxt = rdIdx_r;
    fill_nxt = fill_r;
    wrIdx = IW'((rdIdx_r + fill_r[IW-1:0]) % DEPTH);
    if (flush) begin
      rdIdx_nxt = '0;
      fill_nxt = '0;
    end else begin
      if (doPush) begin
        store_nxt[wrIdx] = pushChar;
      end
      if (doPop) begin
        rdIdx_nxt = wrapInc(rdIdx_r);
      end
      fill_nxt = fill_r + (IW+1)'(doPush) - (IW+1)'(doPop);
    end
  end

  // Register queue state; storage is cleared on reset as well
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdIdx_r <= '0;
      fill_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        store_r[i] <= '0;
      end
    end else begin
      rdIdx_r <= rdIdx_nxt;
      fill_r <= fill_nxt;
      store_r <= store_nxt;
    end
  end

  assign headChar = store_r[rdIdx_r];
  assign notEmpty = (fill_r != '0);
  assign full = (fill_r == (IW+1)'(DEPTH));

endmodule

`default_nettype wire

// ==== hw/serial_rx_map.svh ====
// Register offsets, field positions, reset values and timing counts of the serial receiver
`ifndef SERIAL_RX_MAP_SVH
`define SERIAL_RX_MAP_SVH

// Register offsets (word index on the plain register port)
`define OFS_RECEIVE_STATUS_CONTROL 4'h0
`define OFS_TRANSMIT_STATUS_CONTROL 4'h1
`define OFS_BAUD_CONTROL 4'h2
`define OFS_BAUD_DIVISOR_LOW 4'h3
`define OFS_BAUD_DIVISOR_HIGH 4'h4
`define OFS_RECEIVE_BUFFER_PORT 4'h5
`define OFS_IRQ_STATUS 4'h6
`define OFS_IRQ_MASK 4'h7

// receive_status_control fields
`define BIT_SERIAL_PORT_ON 7
`define BIT_NINTH_BIT_ENABLE 6
`define BIT_RECEIVE_ENABLE 4
`define BIT_STOP_BIT_FAULT 2
`define BIT_OVERFLOW_FAULT 1
`define BIT_RECEIVED_NINTH_BIT 0

// transmit_status_control fields
`define BIT_CLOCKED_MODE 4

// baud_control fields
`define BIT_RECEIVER_IDLE 6

// Interrupt status and mask fields
`define BIT_IRQ_PENDING 0
`define BIT_IRQ_OVERFLOW 1
`define BIT_IRQ_FRAMING 2

// Reset values
`define RST_RECEIVE_STATUS_CONTROL 8'h00
`define RST_TRANSMIT_STATUS_CONTROL 8'h02
`define RST_BAUD_CONTROL 8'h00
`define RST_BAUD_DIVISOR 16'h0000
`define RST_IRQ_MASK 8'h00

// Oversampling and queue figures
`define OVERSAMPLE_RATE 16
`define HALF_BIT_TICKS 8
`define QUEUE_DEPTH 2

`endif

// ==== hw/serial_rx_pkg.sv ====
// Types shared by the serial receiver files
package serial_rx_pkg;

  // One received character with its framing status
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
    logic fault;
  } rx_char_type;

  // Register port request
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [3:0] addr;
    logic [7:0] wrData;
  } reg_req_type;

  // Line recovery states
  typedef enum logic [1:0] {
    IDLE,
    START_CHECK,
    DATA_BITS,
    STOP_BIT
  } recover_state_type;

endpackage

// ==== testbench/serial_rx_checker.sv ====
// Port-level assertions for the serial receiver
`timescale 1ns/100ps
`default_nettype none

module serial_rx_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic serial_in_pin,
  input wire logic irq
);
  // Single clock domain; reset silences every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Write to one index followed at once by a read of it
  sequence wr_rd(logic [3:0] idx);
    regWr && regAddr == idx ##1 regRd && regAddr == idx;
  endsequence

  unmapped_read_a: assert property (regRd && regAddr[3] |=> regRdData == 8'h00)
    else $error("unmapped index returned data");
  rd_quiet_a: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data outside the answer cycle");
  rw_readback_a: assert property ((regWr && regAddr inside {4'h3, 4'h4, 4'h7}) ##1
    (regRd && regAddr == $past(regAddr)) |=> regRdData == $past(regWrData, 2))
    else $error("plain register lost its value");
  ctl_readback_a: assert property (wr_rd(4'h0) |=> (regRdData & 8'hd8) == ($past(regWrData, 2) & 8'hd8))
    else $error("control bits read back wrong");
  ctl_clear_a: assert property ((regWr && regAddr == 4'h0 && !regWrData[7]) ##1
    (regRd && regAddr == 4'h0) |=> regRdData[2:0] == 3'h0)
    else $error("fault bits survive port off");
  tx_ctl_a: assert property (wr_rd(4'h1) |=> regRdData[1] && regRdData[4] == $past(regWrData[4], 2))
    else $error("transmit control read back wrong");
  irq_fall_a: assert property ($fell(irq) |-> $past(regWr) && $past(regAddr) inside {4'h0, 4'h6, 4'h7})
    else $error("interrupt dropped without a write");
  mask_off_a: assert property (regWr && regAddr == 4'h7 && regWrData[2:0] == 3'h0 |=> !irq)
    else $error("interrupt high with all masked");

  // Main scenarios seen
  cover property (wr_rd(4'h0));
  cover property ($fell(irq));
  cover property (regRd && regAddr == 4'h5 ##1 regRdData != 8'h00);
endmodule

bind async_serial_receiver serial_rx_checker chk (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .serial_in_pin(serial_in_pin), .irq(irq));

`default_nettype wire

// ==== testbench/serial_tx_model.sv ====
// Remote asynchronous transmitter driving the serial line
`timescale 1ns/100ps
`default_nettype none

module serial_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys,
  output logic serial_in_pin
);
  // Line idles at mark
  initial serial_in_pin = 1'b1;

  // Hold one level for a bit period; entered just after an edge
  task automatic holdBit(input logic level);
    serial_in_pin <= level;
    repeat (BIT_CLKS) @(posedge clk_sys);
  endtask

  // One character, a chosen stop level, then a bit of idle
  task automatic sendChar(input logic [8:0] value, input int nbits, input logic stopLevel);
    @(posedge clk_sys);
    holdBit(1'b0);
    for (int i = 0; i < nbits; i++) begin
      holdBit(value[i]);
    end
    holdBit(stopLevel);
    holdBit(1'b1);
  endtask

  // Short low pulse, too short to be a start bit
  task automatic glitch(input int clks);
    @(posedge clk_sys);
    serial_in_pin <= 1'b0;
    repeat (clks) @(posedge clk_sys);
    serial_in_pin <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the serial receiver
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int BIT_CLKS = 32; // Divisor 1: two clocks a tick, sixteen ticks a bit
  logic clk_sys; // System clock
  logic nrst; // Active low reset
  logic [3:0] regAddr; // Register index
  logic [7:0] regWrData; // Write data
  logic regWr; // Write strobe
  logic regRd; // Read strobe
  logic [7:0] regRdData; // Read answer
  logic serialLine; // Line from the remote transmitter
  logic irq; // Interrupt
  int err_count; // Mismatches
  int compares; // Comparisons made

  async_serial_receiver dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .serial_in_pin(serialLine), .irq(irq));
  // Pin is a plain input here; direction and analog setup live outside the block
  serial_tx_model #(.BIT_CLKS(BIT_CLKS)) tx (.clk_sys(clk_sys), .serial_in_pin(serialLine));

  // Clock at 20 MHz
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // One-cycle read; answer taken mid-cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
  endtask

  // Write then read the same index with no gap
  task automatic writeRead(input logic [3:0] a, input logic [7:0] d, output logic [7:0] v);
    regWrite(a, d);
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    v = regRdData;
  endtask

  // Read, mask, compare
  task automatic expectReg(input string what, input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    regRead(a, v);
    check(what, v & m, exp);
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset values, unmapped and empty reads
  task automatic test_reset();
    logic [3:0] zeroIdx [6] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'hf};
    expectReg("rx ctl", 4'h0, 8'hff, 8'h00);
    expectReg("tx ctl", 4'h1, 8'hff, 8'h02);
    expectReg("baud ctl", 4'h2, 8'hff, 8'h40);
    foreach (zeroIdx[i]) begin
      expectReg("zero reg", zeroIdx[i], 8'hff, 8'h00);
    end
    expectReg("empty data", 4'h5, 8'hff, 8'h00);
    $display("test_reset done");
  endtask

  // Read-back and receiver setup
  task automatic test_registers();
    logic [7:0] v;
    writeRead(4'h3, 8'h01, v);
    check("div low", v, 8'h01);
    writeRead(4'h4, 8'h00, v);
    check("div high", v, 8'h00);
    writeRead(4'h7, 8'h00, v);
    check("mask", v, 8'h00);
    writeRead(4'h1, 8'h00, v);
    check("tx ctl", v & 8'h12, 8'h02);
    writeRead(4'h0, 8'hff, v);
    check("rx ctl", v & 8'hd8, 8'hd8);
    writeRead(4'h0, 8'h00, v);
    check("rx off", v, 8'h00);
    writeRead(4'h0, 8'h90, v);
    check("rx on", v & 8'hd8, 8'h90);
    $display("test_registers done");
  endtask

  // No reception when disabled or in clocked mode
  task automatic test_disabled();
    regWrite(4'h0, 8'h10);
    tx.sendChar(9'h0f0, 8, 1'b1);
    regWrite(4'h0, 8'h80);
    tx.sendChar(9'h0f0, 8, 1'b1);
    regWrite(4'h0, 8'h90);
    regWrite(4'h1, 8'h10);
    tx.sendChar(9'h0f0, 8, 1'b1);
    regWrite(4'h1, 8'h00);
    expectReg("off status", 4'h6, 8'hff, 8'h00);
    expectReg("off data", 4'h5, 8'hff, 8'h00);
    $display("test_disabled done");
  endtask

  // Plain character, mask and sticky clear
  task automatic test_basic();
    tx.sendChar(9'h01d, 8, 1'b1);
    check("masked irq", {7'h00, irq}, 8'h00);
    expectReg("pending", 4'h6, 8'h07, 8'h01);
    regWrite(4'h7, 8'h07);
    @(negedge clk_sys);
    check("irq", {7'h00, irq}, 8'h01);
    regWrite(4'h7, 8'h00);
    @(negedge clk_sys);
    check("irq masked off", {7'h00, irq}, 8'h00);
    regWrite(4'h7, 8'h07);
    @(negedge clk_sys);
    check("irq again", {7'h00, irq}, 8'h01);
    expectReg("data", 4'h5, 8'hff, 8'h1d);
    expectReg("popped", 4'h5, 8'hff, 8'h00);
    regWrite(4'h6, 8'h01);
    @(negedge clk_sys);
    check("irq cleared", {7'h00, irq}, 8'h00);
    $display("test_basic done");
  endtask

  // False start dropped silently, then a real one
  task automatic test_glitch();
    tx.glitch(4);
    repeat (BIT_CLKS * 12) @(posedge clk_sys);
    expectReg("no char", 4'h6, 8'h07, 8'h00);
    tx.sendChar(9'h0c3, 8, 1'b1);
    expectReg("after drop", 4'h5, 8'hff, 8'hc3);
    regWrite(4'h6, 8'h07);
    $display("test_glitch done");
  endtask

  // Bad stop then good stop back to back
  task automatic test_framing();
    tx.sendChar(9'h081, 8, 1'b0);
    tx.sendChar(9'h042, 8, 1'b1);
    expectReg("fault head", 4'h0, 8'h04, 8'h04);
    expectReg("fault event", 4'h6, 8'h04, 8'h04);
    expectReg("data 1", 4'h5, 8'hff, 8'h81);
    expectReg("fault next", 4'h0, 8'h04, 8'h00);
    expectReg("data 2", 4'h5, 8'hff, 8'h42);
    regWrite(4'h6, 8'h07);
    $display("test_framing done");
  endtask

  // Third character overflows; cleared by receive enable
  task automatic test_overrun();
    tx.sendChar(9'h011, 8, 1'b1);
    tx.sendChar(9'h022, 8, 1'b1);
    tx.sendChar(9'h033, 8, 1'b1);
    expectReg("overflow", 4'h0, 8'h02, 8'h02);
    expectReg("ovf event", 4'h6, 8'h02, 8'h02);
    expectReg("first", 4'h5, 8'hff, 8'h11);
    expectReg("second", 4'h5, 8'hff, 8'h22);
    expectReg("third lost", 4'h5, 8'hff, 8'h00);
    tx.sendChar(9'h044, 8, 1'b1);
    expectReg("locked", 4'h5, 8'hff, 8'h00);
    regWrite(4'h0, 8'h80);
    regWrite(4'h0, 8'h90);
    expectReg("ovf gone", 4'h0, 8'h02, 8'h00);
    tx.sendChar(9'h066, 8, 1'b1);
    expectReg("resumed", 4'h5, 8'hff, 8'h66);
    regWrite(4'h6, 8'h07);
    $display("test_overrun done");
  endtask

  // Nine-bit characters with the top bit apart
  task automatic test_ninth();
    regWrite(4'h0, 8'hd0);
    tx.sendChar(9'h1a5, 9, 1'b1);
    tx.sendChar(9'h05a, 9, 1'b1);
    expectReg("ninth 1", 4'h0, 8'h01, 8'h01);
    expectReg("low 1", 4'h5, 8'hff, 8'ha5);
    expectReg("ninth 0", 4'h0, 8'h01, 8'h00);
    expectReg("low 2", 4'h5, 8'hff, 8'h5a);
    regWrite(4'h0, 8'h90);
    $display("test_ninth done");
  endtask

  // Main sequence
  initial begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    nrst = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    test_reset();
    test_registers();
    test_disabled();
    test_basic();
    test_glitch();
    test_framing();
    test_overrun();
    test_ninth();
    finish_test();
  end

  // Watchdog, well above the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    finish_test();
  end
endmodule

`default_nettype wire
